// *** hw/ipv_pkg.sv ***
// How it works
// - Latency: finish instruction, 13 dispatch, 7 jump
// - Flag read shows every posted source
// - Soft enable off: write 0 clears flag
// - Soft enable on: write 1 posts flag
// - Soft enable is bit 7, rest reserved
// - Masked source still posts, never pends
// - Unmasked posted source pends, bits independent
// - First register bit map, power detect first
// - Second register: capture0, interval, 1 ms
// - Third register: capture1, wrap, ext2, ports
// - Port sources post on edges only
// - Vector read gives top pending vector
// - Any vector write clears all pending
// - Everything resets to zero, all masked
// - Priority order, vector is four times priority
// - Flag stays until taken or cleared
package ipv_pkg;

  localparam int NSRC = 24;
  localparam int PRIO_W = 5;
  localparam int IDX_W = 5;

  // Register offsets
  localparam logic [7:0] OFS_FLAGS_A = 8'hda;
  localparam logic [7:0] OFS_FLAGS_B = 8'hdb;
  localparam logic [7:0] OFS_FLAGS_C = 8'hdc;
  localparam logic [7:0] OFS_SOFT_EN = 8'hde;
  localparam logic [7:0] OFS_PEND_C = 8'hdf;
  localparam logic [7:0] OFS_PEND_A = 8'he0;
  localparam logic [7:0] OFS_PEND_B = 8'he1;
  localparam logic [7:0] OFS_VECTOR = 8'he2;
  localparam logic [7:0] OFS_STATUS = 8'he3;
  localparam logic [7:0] OFS_IRQ_MASK = 8'he4;

  localparam int SOFT_EN_BIT = 7;

  // Implemented bits over the three flag registers, C:B:A
  localparam logic [NSRC-1:0] SRC_VALID = 24'h77e0ff;

  // Flat source positions (A 0..7, B 8..15, C 16..23)
  localparam int SRC_LVD = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_SER_TX = 2;
  localparam int SRC_SER_RX = 3;
  localparam int SRC_PORT0 = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_SLEEP = 6;
  localparam int SRC_PORT1 = 7;
  localparam int SRC_MS1 = 13;
  localparam int SRC_PIT = 14;
  localparam int SRC_CAP0 = 15;
  localparam int SRC_CAP1 = 16;
  localparam int SRC_WRAP = 17;
  localparam int SRC_EXT2 = 18;
  localparam int SRC_PORT2 = 20;
  localparam int SRC_PORT3 = 21;
  localparam int SRC_PORT4 = 22;

  // Priority number per flat position; lower wins, 0 marks unused
  localparam logic [PRIO_W-1:0] SRC_PRIO [NSRC] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h19, 5'h06,
    5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h0d, 5'h0e, 5'h0f,
    5'h10, 5'h11, 5'h12, 5'h00, 5'h14, 5'h15, 5'h16, 5'h00};

  localparam int VEC_SHIFT = 2;

  // CPU side dispatch figures
  localparam int DISPATCH_CYCLES = 13;
  localparam int LONG_JUMP_CYCLES = 7;

  // Own status / mask register bits
  localparam int ST_HW_POST = 0;
  localparam int ST_SW_POST = 1;
  localparam int ST_VEC_CLR = 2;
  localparam int ST_TAKEN = 3;
  localparam int ST_W = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ipv_bus_req_t;

  typedef struct packed {
    logic low_supply_detect;
    logic ext0;
    logic ser_tx;
    logic ser_rx;
    logic ext1;
    logic sleep;
    logic ms1;
    logic pit;
    logic cap0;
    logic cap1;
    logic wrap;
    logic ext2;
  } ipv_src_t;

endpackage

// *** hw/ipv_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipv_ctrl (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ipv_pkg::ipv_bus_req_t bus_in,
  output logic [7:0] rdata_out,
  input wire ipv_pkg::ipv_src_t src_in,
  input wire logic [4:0] port_level_in,
  input wire logic cpu_ack_in,
  output logic cpu_irq_out,
  output logic [7:0] cpu_vector_out,
  output logic irq_out
);

  localparam int N = ipv_pkg::NSRC;

  logic [N-1:0] posted_q;
  logic [N-1:0] posted_d;
  logic [N-1:0] mask_q;
  logic [N-1:0] mask_d;
  logic swen_q;
  logic swen_d;
  logic [4:0] port_prev_q;
  logic [4:0] port_prev_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic cpu_irq_q;
  logic cpu_irq_d;
  logic [7:0] cpu_vec_q;
  logic [7:0] cpu_vec_d;
  logic [ipv_pkg::IDX_W-1:0] idx_q;
  logic [ipv_pkg::IDX_W-1:0] idx_d;
  logic [ipv_pkg::ST_W-1:0] stat_q;
  logic [ipv_pkg::ST_W-1:0] stat_d;
  logic [ipv_pkg::ST_W-1:0] imask_q;
  logic [ipv_pkg::ST_W-1:0] imask_d;

  logic [N-1:0] ev;
  logic [N-1:0] pend;
  logic [N-1:0] wsel;
  logic [N-1:0] wdat;
  logic [N-1:0] sw_set;
  logic [4:0] port_rise;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_vc;
  logic ack_take;
  logic any_pend;
  logic [ipv_pkg::PRIO_W-1:0] best_prio;
  logic [ipv_pkg::IDX_W-1:0] best_idx;
  logic [7:0] top_vec;

  // Port sources post on a rising edge of their condition
  assign port_rise = port_level_in & ~port_prev_q;

  always_comb
  begin
    ev = '0;
    ev[ipv_pkg::SRC_LVD] = src_in.low_supply_detect;
    ev[ipv_pkg::SRC_EXT0] = src_in.ext0;
    ev[ipv_pkg::SRC_SER_TX] = src_in.ser_tx;
    ev[ipv_pkg::SRC_SER_RX] = src_in.ser_rx;
    ev[ipv_pkg::SRC_PORT0] = port_rise[0];
    ev[ipv_pkg::SRC_EXT1] = src_in.ext1;
    ev[ipv_pkg::SRC_SLEEP] = src_in.sleep;
    ev[ipv_pkg::SRC_PORT1] = port_rise[1];
    ev[ipv_pkg::SRC_MS1] = src_in.ms1;
    ev[ipv_pkg::SRC_PIT] = src_in.pit;
    ev[ipv_pkg::SRC_CAP0] = src_in.cap0;
    ev[ipv_pkg::SRC_CAP1] = src_in.cap1;
    ev[ipv_pkg::SRC_WRAP] = src_in.wrap;
    ev[ipv_pkg::SRC_EXT2] = src_in.ext2;
    ev[ipv_pkg::SRC_PORT2] = port_rise[2];
    ev[ipv_pkg::SRC_PORT3] = port_rise[3];
    ev[ipv_pkg::SRC_PORT4] = port_rise[4];
  end

  assign wr_a = bus_in.wr && (bus_in.addr == ipv_pkg::OFS_FLAGS_A);
  assign wr_b = bus_in.wr && (bus_in.addr == ipv_pkg::OFS_FLAGS_B);
  assign wr_c = bus_in.wr && (bus_in.addr == ipv_pkg::OFS_FLAGS_C);
  assign wr_vc = bus_in.wr && (bus_in.addr == ipv_pkg::OFS_VECTOR);
  assign wsel = {{8{wr_c}}, {8{wr_b}}, {8{wr_a}}};
  assign wdat = {3{bus_in.wdata}};
  assign pend = posted_q & mask_q;
  assign ack_take = cpu_ack_in && cpu_irq_q;
  assign sw_set = wsel & wdat & {N{swen_q}} & ipv_pkg::SRC_VALID;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_src
      logic clr;
      // Soft clear, vector-write clear of pending, CPU take
      assign clr = (wsel[gi] && !swen_q && !wdat[gi])
                   || (wr_vc && mask_q[gi])
                   || (ack_take && idx_q == gi);
      // Set terms win over any clear in the same cycle
      assign posted_d[gi] = ipv_pkg::SRC_VALID[gi]
                            && ((posted_q[gi] && !clr)
                                || ev[gi]
                                || sw_set[gi]);
    end
  endgenerate

  // Highest-priority pending source
  always_comb
  begin
    any_pend = 1'b0;
    best_prio = '0;
    best_idx = '0;
    for (int i = 0; i < N; i++)
    begin
      if (pend[i] && (!any_pend || ipv_pkg::SRC_PRIO[i] < best_prio))
      begin
        any_pend = 1'b1;
        best_prio = ipv_pkg::SRC_PRIO[i];
        best_idx = ipv_pkg::IDX_W'(i);
      end
    end
    top_vec = 8'(best_prio) << ipv_pkg::VEC_SHIFT;
  end

  always_comb
  begin
    mask_d = mask_q;
    swen_d = swen_q;
    imask_d = imask_q;
    port_prev_d = port_level_in;
    if (bus_in.wr)
    begin
      case (bus_in.addr)
        ipv_pkg::OFS_PEND_A:
          mask_d[7:0] = bus_in.wdata & ipv_pkg::SRC_VALID[7:0];
        ipv_pkg::OFS_PEND_B:
          mask_d[15:8] = bus_in.wdata & ipv_pkg::SRC_VALID[15:8];
        ipv_pkg::OFS_PEND_C:
          mask_d[23:16] = bus_in.wdata & ipv_pkg::SRC_VALID[23:16];
        ipv_pkg::OFS_SOFT_EN:
          swen_d = bus_in.wdata[ipv_pkg::SOFT_EN_BIT];
        ipv_pkg::OFS_IRQ_MASK:
          imask_d = bus_in.wdata[ipv_pkg::ST_W-1:0];
        default:
          mask_d = mask_q;
      endcase
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_comb
  begin
    rdata_d = '0;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        ipv_pkg::OFS_FLAGS_A: rdata_d = posted_q[7:0];
        ipv_pkg::OFS_FLAGS_B: rdata_d = posted_q[15:8];
        ipv_pkg::OFS_FLAGS_C: rdata_d = posted_q[23:16];
        ipv_pkg::OFS_PEND_A: rdata_d = mask_q[7:0];
        ipv_pkg::OFS_PEND_B: rdata_d = mask_q[15:8];
        ipv_pkg::OFS_PEND_C: rdata_d = mask_q[23:16];
        ipv_pkg::OFS_SOFT_EN:
          rdata_d = {swen_q, 7'h00};
        ipv_pkg::OFS_VECTOR: rdata_d = top_vec;
        ipv_pkg::OFS_STATUS: rdata_d = 8'(stat_q);
        ipv_pkg::OFS_IRQ_MASK: rdata_d = 8'(imask_q);
        default: rdata_d = '0;
      endcase
    end
  end

  // Sticky status; a read clears, a new event in that cycle wins
  always_comb
  begin
    stat_d = stat_q;
    if (bus_in.rd && bus_in.addr == ipv_pkg::OFS_STATUS)
      stat_d = '0;
    if (|ev)
      stat_d[ipv_pkg::ST_HW_POST] = 1'b1;
    if (|sw_set)
      stat_d[ipv_pkg::ST_SW_POST] = 1'b1;
    if (wr_vc)
      stat_d[ipv_pkg::ST_VEC_CLR] = 1'b1;
    if (ack_take)
      stat_d[ipv_pkg::ST_TAKEN] = 1'b1;
  end

  // Presented to the CPU; it dispatches only with its global enable set
  always_comb
  begin
    cpu_irq_d = any_pend;
    cpu_vec_d = top_vec;
    idx_d = best_idx;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      posted_q <= '0;
      mask_q <= '0;
      swen_q <= 1'b0;
      port_prev_q <= '0;
      rdata_q <= '0;
      cpu_irq_q <= 1'b0;
      cpu_vec_q <= '0;
      idx_q <= '0;
      stat_q <= '0;
      imask_q <= '0;
    end
    else
    begin
      posted_q <= posted_d;
      mask_q <= mask_d;
      swen_q <= swen_d;
      port_prev_q <= port_prev_d;
      rdata_q <= rdata_d;
      cpu_irq_q <= cpu_irq_d;
      cpu_vec_q <= cpu_vec_d;
      idx_q <= idx_d;
      stat_q <= stat_d;
      imask_q <= imask_d;
    end
  end

  // Vector registered every cycle from the top pending source; the CPU latches it when it takes
  assign cpu_irq_out = cpu_irq_q;
  assign cpu_vector_out = cpu_vec_q;
  assign rdata_out = rdata_q;
  assign irq_out = |(stat_q & imask_q);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  chk_read_posted: assert property (
    bus_in.rd && bus_in.addr == ipv_pkg::OFS_FLAGS_A
    |=> rdata_out == $past(posted_q[7:0]))
    else $error("posted flag read wrong");

  chk_soft_clear: assert property (
    wr_a && !swen_q
    |=> posted_q[7:0] == (($past(posted_q[7:0]) & $past(bus_in.wdata))
                           | $past(ev[7:0])))
    else $error("soft clear wrong");

  chk_soft_post: assert property (
    wr_a && swen_q
    |=> (posted_q[7:0] & $past(bus_in.wdata)) == $past(bus_in.wdata)
        && (posted_q[7:0] & $past(posted_q[7:0])) == $past(posted_q[7:0]))
    else $error("soft post wrong");

  chk_masked_post: assert property (
    ev[ipv_pkg::SRC_EXT0] && !mask_q[ipv_pkg::SRC_EXT0] && !bus_in.wr
    |=> posted_q[ipv_pkg::SRC_EXT0] && !pend[ipv_pkg::SRC_EXT0])
    else $error("masked source misbehaves");

  chk_vector_read: assert property (
    bus_in.rd && bus_in.addr == ipv_pkg::OFS_VECTOR
    |=> rdata_out == cpu_vector_out)
    else $error("vector read wrong");

  chk_rdata_idle: assert property (
    !bus_in.rd |=> rdata_out == '0)
    else $error("read data without read");

  chk_vc_clear: assert property (
    wr_vc && ev == '0 && !ack_take
    |=> pend == '0 ##1 !cpu_irq_out)
    else $error("vector write left pending");

  chk_ack_clear: assert property (
    ack_take && !ev[idx_q] && !sw_set[idx_q]
    |=> !posted_q[$past(idx_q)])
    else $error("taken flag not cleared");

  chk_port_edge: assert property (
    port_level_in[0] && port_prev_q[0] && !posted_q[ipv_pkg::SRC_PORT0]
    && !bus_in.wr
    |=> !posted_q[ipv_pkg::SRC_PORT0])
    else $error("port level posted");

  chk_vec_range: assert property (
    cpu_irq_out |-> cpu_vector_out >= 8'h04 && cpu_vector_out <= 8'h64
                    && cpu_vector_out[1:0] == 2'h0)
    else $error("vector out of range");

  chk_event_wins: assert property (
    ev[ipv_pkg::SRC_LVD] |=> posted_q[ipv_pkg::SRC_LVD])
    else $error("event lost");

endmodule
`default_nettype wire

// *** verif/ipv_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipv_cpu_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic irq_in,
  input wire logic [7:0] vector_in,
  input wire logic gie_set_in,
  output logic ack_out,
  output logic isr_start_out,
  output logic [7:0] taken_vec_out
);
  logic gie_q;
  int wait_q;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      gie_q <= 1'b0;
      wait_q <= 0;
      ack_out <= 1'b0;
      isr_start_out <= 1'b0;
      taken_vec_out <= 8'h00;
    end
    else
    begin
      ack_out <= 1'b0;
      isr_start_out <= 1'b0;
      if (gie_set_in)
        gie_q <= 1'b1;
      if (gie_q && irq_in && wait_q == 0 && !ack_out)
      begin
        // Take and lock out further takes
        ack_out <= 1'b1;
        gie_q <= 1'b0;
        taken_vec_out <= vector_in;
        wait_q <= ipv_pkg::DISPATCH_CYCLES + ipv_pkg::LONG_JUMP_CYCLES;
      end
      else if (wait_q > 0)
      begin
        wait_q <= wait_q - 1;
        isr_start_out <= (wait_q == 1);
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/interrupt_post_mask_vector_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module interrupt_post_mask_vector_bench;
  logic clk_in, rstn_in, gie_set, ack, isr, cpu_irq, irq;
  logic [7:0] rdata, cvec, tvec;
  logic [4:0] port;
  logic [11:0] src;
  logic [27:0] r;
  ipv_pkg::ipv_bus_req_t bus;
  int miscompares, checked, n;
  // Port flag, source index, group, flag bit, vector
  logic [27:0] rows [17] = '{28'h0000104, 28'h0100208, 28'h020040c,
    28'h0300810, 28'h1001014, 28'h040201c, 28'h0504064, 28'h1108018,
    28'h0612034, 28'h0714038, 28'h081803c, 28'h0920140, 28'h0a20244,
    28'h0b20448, 28'h1221050, 28'h1322054, 28'h1424058};
  logic [7:0] fo [3] = '{8'hda, 8'hdb, 8'hdc};
  logic [7:0] mo [3] = '{8'he0, 8'he1, 8'hdf};
  ipv_ctrl i_ipv_ctrl (.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus),
    .rdata_out(rdata), .src_in(ipv_pkg::ipv_src_t'(src)),
    .port_level_in(port), .cpu_ack_in(ack), .cpu_irq_out(cpu_irq),
    .cpu_vector_out(cvec), .irq_out(irq));
  ipv_cpu_model i_ipv_cpu_model (.clk_in(clk_in), .rstn_in(rstn_in),
    .irq_in(cpu_irq), .vector_in(cvec), .gie_set_in(gie_set),
    .ack_out(ack), .isr_start_out(isr), .taken_vec_out(tvec));
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask
  task automatic pulse(input logic [3:0] s);
    @(posedge clk_in);
    src <= 12'h800 >> s;
    @(posedge clk_in);
    src <= 12'h000;
  endtask
  task automatic bound(input int k);
    if (k >= 60)
    begin
      miscompares++;
      report_and_stop;
    end
  endtask
  initial
  begin
    bus = '0;
    src = 12'h000;
    port = 5'h00;
    gie_set = 1'b0;
    rstn_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      wr(mo[r[17:16]], r[15:8]);
      if (r[24])
      begin
        @(posedge clk_in);
        port <= 5'h01 << r[23:20];
        repeat (2) @(posedge clk_in);
      end
      else
        pulse(r[23:20]);
      rc(fo[r[17:16]], r[15:8]);
      chk1(cpu_irq, 1'b1);
      chk8(cvec, r[7:0]);
      rc(8'he2, r[7:0]);
      wr(fo[r[17:16]], ~r[15:8]);
      rc(fo[r[17:16]], 8'h00);
      wr(mo[r[17:16]], 8'h00);
      port <= 5'h00;
    end
    pulse(4'h1);
    rc(8'hda, 8'h02);
    chk1(cpu_irq, 1'b0);
    wr(8'he0, 8'h42);
    pulse(4'h5);
    repeat (2) @(posedge clk_in);
    #1 chk8(cvec, 8'h08);
    @(posedge clk_in);
    gie_set <= 1'b1;
    @(posedge clk_in);
    gie_set <= 1'b0;
    for (n = 0; !ack && n < 60; n++)
      @(posedge clk_in) #1;
    bound(n);
    chk8(tvec, 8'h08);
    for (n = 0; !isr && n < 60; n++)
      @(posedge clk_in) #1;
    bound(n);
    chk8(n[7:0], 8'h14);
    rc(8'hda, 8'h40);
    chk8(cvec, 8'h64);
    rc(8'he3, 8'h09);
    wr(8'he4, 8'h01);
    pulse(4'h3);
    repeat (2) @(posedge clk_in);
    #1 chk1(irq, 1'b1);
    rc(8'he3, 8'h01);
    chk1(irq, 1'b0);
    wr(8'he4, 8'h00);
    pulse(4'h3);
    repeat (2) @(posedge clk_in);
    #1 chk1(irq, 1'b0);
    wr(8'hde, 8'hff);
    rc(8'hde, 8'h80);
    wr(8'hdb, 8'hff);
    rc(8'hdb, 8'he0);
    wr(8'hdb, 8'h00);
    rc(8'hdb, 8'he0);
    wr(8'hda, 8'h01);
    rc(8'hda, 8'h49);
    wr(8'hde, 8'h00);
    wr(8'hdb, 8'hdf);
    rc(8'hdb, 8'hc0);
    wr(8'he1, 8'h80);
    rc(8'he3, 8'h03);
    wr(8'he2, 8'h5a);
    rc(8'hdb, 8'h40);
    rc(8'hda, 8'h09);
    rc(8'he3, 8'h04);
    chk1(cpu_irq, 1'b0);
    fork
      wr(8'hda, 8'h00);
      pulse(4'h4);
    join
    rc(8'hda, 8'h20);
    wr(8'hd0, 8'hff);
    rc(8'hd0, 8'h00);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      rc(fo[k], 8'h00);
      rc(mo[k], 8'h00);
    end
    rc(8'hde, 8'h00);
    rc(8'he2, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
